// [ldc_defs.svh]
// register offsets, field positions and reset values of the led drive configuration bank
// assumes a classic wishbone slave with 32-bit data, one word per register
//
// Notes on behaviour
// - led drivers a and b each take a 3-bit edge rate code, 0 slowest and 7 fastest, reset 0.
// - led drivers a and b each take a 4-bit coarse current code, reset 0, term 50.3 + 19.8 x code.
// - each driver's peak current target is coarse term times fine multiplier times scale factor.
// - driver b full-strength bit 13 resets to 1; clearing it selects low-power mode.
// - the fine trim register holds c at 15:11, b at 10:6, a at 4:0, each reset 0xc.
// - first slot pulse width is bits 12:8 in 1 us units, reset 3.
// - first slot pulse delay is bits 7:0 in 1 us units, reset 0x20, delay before the pulse.
// - driver a full-strength bit 13 resets to 1; clearing it gives one tenth current.
// - a 2-bit first slot driver select picks driver a to c with codes 1 to 3, code 0 float mode.
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// offsets are register indices; the byte address is four times the index
`define LDC_IDX_SLOT_SEL      8'h14
`define LDC_IDX_A_DRIVE       8'h23
`define LDC_IDX_B_DRIVE       8'h24
`define LDC_IDX_FINE          8'h25
`define LDC_IDX_SLOT_TIMING   8'h30
`define LDC_IDX_NONE          8'hff

`define LDC_RATE_HI           6
`define LDC_RATE_LO           4
`define LDC_COARSE_HI         3
`define LDC_COARSE_LO         0
`define LDC_STRENGTH_BIT      13
`define LDC_RSVD_ONE_BIT      12
`define LDC_FINE_C_HI         15
`define LDC_FINE_C_LO         11
`define LDC_FINE_B_HI         10
`define LDC_FINE_B_LO         6
`define LDC_FINE_A_HI         4
`define LDC_FINE_A_LO         0
`define LDC_WIDTH_HI          12
`define LDC_WIDTH_LO          8
`define LDC_DELAY_HI          7
`define LDC_DELAY_LO          0
`define LDC_SEL_HI            1
`define LDC_SEL_LO            0
`define LDC_LANE0_HI          7
`define LDC_LANE1_LO          8
`define LDC_LANES             2

`define LDC_RST_RATE          3'h0
`define LDC_RST_COARSE        4'h0
`define LDC_RST_STRENGTH      1'h1
`define LDC_RST_FINE          5'h0c
`define LDC_RST_WIDTH         5'h03
`define LDC_RST_DELAY         8'h20
`define LDC_RST_SEL           2'h1

`endif

// [ldc_pkg.sv]
// types of the led drive configuration bank
// assumes ldc_defs.svh is compiled with it
package ldc_pkg;

    typedef enum logic [1:0] {
        LDC_SEL_FLOAT = 2'h0,
        LDC_SEL_A     = 2'h1,
        LDC_SEL_B     = 2'h2,
        LDC_SEL_C     = 2'h3
    } ldc_sel_t;

    typedef struct packed {
        logic [2:0]  a_rate;
        logic [3:0]  a_coarse;
        logic        a_full;
        logic [2:0]  b_rate;
        logic [3:0]  b_coarse;
        logic        b_full;
        logic [4:0]  a_fine;
        logic [4:0]  b_fine;
        logic [4:0]  c_fine;
        logic [4:0]  width;
        logic [7:0]  delay;
        ldc_sel_t    sel;
        logic        ack;
        logic [31:0] dat;
    } ldc_state_t;

endpackage

// [ldc_regs.sv]
// led drive configuration bank behind a classic wishbone slave
// assumes a 40 mhz clk shared with the bus master and a synchronous active-low reset
// reserved bits are not stored; reads return their defaults
// ce low freezes every register, the bus handshake included
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "ldc_defs.svh"

module ldc_regs
    import ldc_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // ------------------------------------------------------------
    // clock, reset and clock enable
    // ------------------------------------------------------------
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_we_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // ------------------------------------------------------------
    // drive settings of drivers a and b
    // ------------------------------------------------------------
    output logic [2:0]             led_a_edge_rate,
    output logic [3:0]             led_a_coarse_current,
    output logic                   led_a_full_strength,
    output logic [2:0]             led_b_edge_rate,
    output logic [3:0]             led_b_coarse_current,
    output logic                   led_b_full_strength,
    // ------------------------------------------------------------
    // fine trim multipliers
    // ------------------------------------------------------------
    output logic [4:0]             led_a_fine_trim,
    output logic [4:0]             led_b_fine_trim,
    output logic [4:0]             led_c_fine_trim,
    // ------------------------------------------------------------
    // first slot timing and driver
    // ------------------------------------------------------------
    output logic [4:0]             first_slot_pulse_width,
    output logic [7:0]             first_slot_pulse_delay,
    output logic [1:0]             first_slot_driver_select
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("ldc_regs: ADDR_W must lie in 8..32");
    end

    ldc_state_t s_r;
    ldc_state_t s_nxt;
    logic       req;
    logic [7:0] idx;
    logic       lo_we;
    logic       hi_we;
    logic [15:0] wd;
    localparam int IDX_W = ADDR_W - 2;
    logic [`LDC_LANES-1:0] lane_we;
    logic [IDX_W-1:0]      word_idx;

    // ------------------------------------------------------------
    // field map check
    // ------------------------------------------------------------
    // header and state struct must agree, or a field would be cut without notice
    localparam int RATE_W   = `LDC_RATE_HI - `LDC_RATE_LO + 1;
    localparam int COARSE_W = `LDC_COARSE_HI - `LDC_COARSE_LO + 1;
    localparam int FINE_W   = `LDC_FINE_A_HI - `LDC_FINE_A_LO + 1;
    localparam int WIDTH_W  = `LDC_WIDTH_HI - `LDC_WIDTH_LO + 1;
    localparam int DELAY_W  = `LDC_DELAY_HI - `LDC_DELAY_LO + 1;
    localparam int SEL_W    = `LDC_SEL_HI - `LDC_SEL_LO + 1;
    // bits of the b trim that arrive on lane 0; the rest arrive on lane 1
    localparam int B_SPLIT  = `LDC_LANE0_HI - `LDC_FINE_B_LO + 1;

    if (RATE_W != $bits(s_r.a_rate) || COARSE_W != $bits(s_r.a_coarse)) begin : g_bad_drive
        $error("ldc_regs: drive field map does not fit the state");
    end
    if (FINE_W != $bits(s_r.a_fine)
            || `LDC_FINE_B_HI - `LDC_FINE_B_LO + 1 != FINE_W
            || `LDC_FINE_C_HI - `LDC_FINE_C_LO + 1 != FINE_W) begin : g_bad_fine
        $error("ldc_regs: fine trim fields must share one width");
    end
    if (B_SPLIT < 1 || B_SPLIT >= FINE_W) begin : g_bad_split
        $error("ldc_regs: b trim must straddle the lane boundary");
    end
    if (WIDTH_W != $bits(s_r.width) || DELAY_W != $bits(s_r.delay)) begin : g_bad_timing
        $error("ldc_regs: slot timing field map does not fit the state");
    end
    if (SEL_W != $bits(s_r.sel)) begin : g_bad_sel
        $error("ldc_regs: driver select field map does not fit the state");
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a request is taken once; ack high blocks a second take in its cycle
    assign req      = wb_cyc_i && wb_stb_i && !s_r.ack;
    assign word_idx = wb_adr_i[ADDR_W-1:2];
    // indices beyond the byte-wide map fold onto an unmapped code
    assign idx      = (word_idx > IDX_W'(`LDC_IDX_NONE)) ? `LDC_IDX_NONE : 8'(word_idx);
    // one strobe per byte lane; lanes 2 and 3 carry no register bits
    for (genvar ln = 0; ln < `LDC_LANES; ln++) begin : g_lane
        assign lane_we[ln] = req && wb_we_i && wb_sel_i[ln];
    end
    assign lo_we    = lane_we[0];
    assign hi_we    = lane_we[1];
    assign wd       = wb_dat_i[15:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // fields only store codes; the analog drivers turn them into current
    // reserved bits are not stored, software keeps them at default
    always_comb begin
        s_nxt     = s_r;
        s_nxt.ack = req;
        s_nxt.dat = 32'h0;
        unique case (idx)
            `LDC_IDX_A_DRIVE: begin
                if (lo_we) begin
                    s_nxt.a_rate   = wd[`LDC_RATE_HI:`LDC_RATE_LO];
                    s_nxt.a_coarse = wd[`LDC_COARSE_HI:`LDC_COARSE_LO];
                end
                if (hi_we) begin
                    s_nxt.a_full = wd[`LDC_STRENGTH_BIT];
                end
                s_nxt.dat[`LDC_STRENGTH_BIT]             = s_r.a_full;
                s_nxt.dat[`LDC_RSVD_ONE_BIT]             = 1'b1;
                s_nxt.dat[`LDC_RATE_HI:`LDC_RATE_LO]     = s_r.a_rate;
                s_nxt.dat[`LDC_COARSE_HI:`LDC_COARSE_LO] = s_r.a_coarse;
            end
            `LDC_IDX_B_DRIVE: begin
                if (lo_we) begin
                    s_nxt.b_rate   = wd[`LDC_RATE_HI:`LDC_RATE_LO];
                    s_nxt.b_coarse = wd[`LDC_COARSE_HI:`LDC_COARSE_LO];
                end
                if (hi_we) begin
                    s_nxt.b_full = wd[`LDC_STRENGTH_BIT];
                end
                s_nxt.dat[`LDC_STRENGTH_BIT]             = s_r.b_full;
                s_nxt.dat[`LDC_RSVD_ONE_BIT]             = 1'b1;
                s_nxt.dat[`LDC_RATE_HI:`LDC_RATE_LO]     = s_r.b_rate;
                s_nxt.dat[`LDC_COARSE_HI:`LDC_COARSE_LO] = s_r.b_coarse;
            end
            `LDC_IDX_FINE: begin
                // field b straddles both byte lanes, so each lane updates its own bits
                if (lo_we) begin
                    s_nxt.a_fine      = wd[`LDC_FINE_A_HI:`LDC_FINE_A_LO];
                    s_nxt.b_fine[B_SPLIT-1:0] = wd[`LDC_LANE0_HI:`LDC_FINE_B_LO];
                end
                if (hi_we) begin
                    s_nxt.b_fine[FINE_W-1:B_SPLIT] = wd[`LDC_FINE_B_HI:`LDC_LANE1_LO];
                    s_nxt.c_fine      = wd[`LDC_FINE_C_HI:`LDC_FINE_C_LO];
                end
                s_nxt.dat[`LDC_FINE_C_HI:`LDC_FINE_C_LO] = s_r.c_fine;
                s_nxt.dat[`LDC_FINE_B_HI:`LDC_FINE_B_LO] = s_r.b_fine;
                s_nxt.dat[`LDC_FINE_A_HI:`LDC_FINE_A_LO] = s_r.a_fine;
            end
            `LDC_IDX_SLOT_TIMING: begin
                if (hi_we) begin
                    s_nxt.width = wd[`LDC_WIDTH_HI:`LDC_WIDTH_LO];
                end
                if (lo_we) begin
                    s_nxt.delay = wd[`LDC_DELAY_HI:`LDC_DELAY_LO];
                end
                s_nxt.dat[`LDC_WIDTH_HI:`LDC_WIDTH_LO] = s_r.width;
                s_nxt.dat[`LDC_DELAY_HI:`LDC_DELAY_LO] = s_r.delay;
            end
            `LDC_IDX_SLOT_SEL: begin
                if (lo_we) begin
                    s_nxt.sel = ldc_sel_t'(wd[`LDC_SEL_HI:`LDC_SEL_LO]);
                end
                s_nxt.dat[`LDC_SEL_HI:`LDC_SEL_LO] = s_r.sel;
            end
            default: begin
                // unmapped words ack, ignore writes and read zero
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r          <= '0;
            s_r.a_rate   <= `LDC_RST_RATE;
            s_r.b_rate   <= `LDC_RST_RATE;
            s_r.a_coarse <= `LDC_RST_COARSE;
            s_r.b_coarse <= `LDC_RST_COARSE;
            s_r.a_full   <= `LDC_RST_STRENGTH;
            s_r.b_full   <= `LDC_RST_STRENGTH;
            s_r.a_fine   <= `LDC_RST_FINE;
            s_r.b_fine   <= `LDC_RST_FINE;
            s_r.c_fine   <= `LDC_RST_FINE;
            s_r.width    <= `LDC_RST_WIDTH;
            s_r.delay    <= `LDC_RST_DELAY;
            s_r.sel      <= ldc_sel_t'(`LDC_RST_SEL);
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o                 = s_r.ack;
    assign wb_dat_o                 = s_r.dat;
    assign led_a_edge_rate          = s_r.a_rate;
    assign led_a_coarse_current     = s_r.a_coarse;
    assign led_a_full_strength      = s_r.a_full;
    assign led_b_edge_rate          = s_r.b_rate;
    assign led_b_coarse_current     = s_r.b_coarse;
    assign led_b_full_strength      = s_r.b_full;
    assign led_a_fine_trim          = s_r.a_fine;
    assign led_b_fine_trim          = s_r.b_fine;
    assign led_c_fine_trim          = s_r.c_fine;
    assign first_slot_pulse_width   = s_r.width;
    assign first_slot_pulse_delay   = s_r.delay;
    assign first_slot_driver_select = s_r.sel;

endmodule

// [ldc_assertions.sv]
// assertions for the led drive bank, bound into ldc_regs
// assumes classic wishbone with ack one cycle after a take
`timescale 1ns/1ps
module ldc_chk #(
    parameter int ADDR_W = 10
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic              wb_we_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic [3:0]        led_a_coarse_current,
    input wire logic              led_b_full_strength,
    input wire logic [4:0]        led_c_fine_trim,
    input wire logic [7:0]        first_slot_pulse_delay,
    input wire logic [1:0]        first_slot_driver_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a write taken at this edge to one index with the given byte lane enabled; other lanes may be enabled too
    sequence s_wr(idx, lane);
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
            && wb_adr_i[ADDR_W-1:2] == idx && wb_sel_i[lane];
    endsequence
    a_ack_next: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_drops: assert property (ce && wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    // a low ce freezes the handshake and the pulse delay alike
    a_ce_freeze: assert property (!ce |=> $stable(wb_ack_o) && $stable(first_slot_pulse_delay))
        else $error("state moved while ce low");
    a_coarse_a: assert property (s_wr(8'h23, 0) |=> led_a_coarse_current == $past(wb_dat_i[3:0]))
        else $error("coarse a wrong");
    a_strength_b: assert property (s_wr(8'h24, 1) |=> led_b_full_strength == $past(wb_dat_i[13]))
        else $error("strength b wrong");
    a_fine_c: assert property (s_wr(8'h25, 1) |=> led_c_fine_trim == $past(wb_dat_i[15:11]))
        else $error("fine c wrong");
    a_delay_wr: assert property (s_wr(8'h30, 0) |=> first_slot_pulse_delay == $past(wb_dat_i[7:0]))
        else $error("delay wrong");
    a_sel_write: assert property (s_wr(8'h14, 0) |=> first_slot_driver_select == $past(wb_dat_i[1:0]))
        else $error("select wrong");
    // a one-edge reset may move the select, so changes right after reset are excused
    a_sel_hold: assert property (!$stable(first_slot_driver_select) && $past(rst_n) |-> wb_ack_o
        && $past(wb_we_i && wb_adr_i[ADDR_W-1:2] == 8'h14)) else $error("select moved");
endmodule
bind ldc_regs ldc_chk #(.ADDR_W(ADDR_W)) chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .led_a_coarse_current(led_a_coarse_current), .led_b_full_strength(led_b_full_strength),
    .led_c_fine_trim(led_c_fine_trim), .first_slot_pulse_delay(first_slot_pulse_delay),
    .first_slot_driver_select(first_slot_driver_select));

// [tb_ldc_regs.sv]
// self-checking bench for ldc_regs
// assumes the bank answers one cycle after a take; ce drops only in the freeze scenario
`timescale 1ns/1ps
module tb_ldc_regs import ldc_pkg::*; ;
    logic        clk = 0, rst_n = 0, ce = 1, cyc = 0, stb = 0, we = 0, ack, fa, fb;
    logic [9:0]  adr = '0;
    logic [31:0] dat = '0, rdat;
    logic [3:0]  sel = '0, ca, cb;
    logic [2:0]  ra, rb;
    logic [4:0]  ta, tbb, tc, w;
    logic [7:0]  dl;
    logic [1:0]  ds;
    logic [15:0] exp_q[$], d;
    logic [9:0]  ad[5] = '{10'h08c, 10'h090, 10'h094, 10'h0c0, 10'h050};
    logic [15:0] mk[5] = '{16'h207f, 16'h207f, 16'hffdf, 16'h1fff, 16'h0003};
    int          bad_count = 0, checks = 0;
    always #12.5 clk = ~clk;
    ldc_regs uut (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .led_a_edge_rate(ra), .led_a_coarse_current(ca),
        .led_a_full_strength(fa), .led_b_edge_rate(rb), .led_b_coarse_current(cb),
        .led_b_full_strength(fb), .led_a_fine_trim(ta), .led_b_fine_trim(tbb),
        .led_c_fine_trim(tc), .first_slot_pulse_width(w), .first_slot_pulse_delay(dl),
        .first_slot_driver_select(ds));
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("Error t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("Error t=%0t pin %h want %h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one classic cycle; held until ack is sampled high, then released
    task automatic bus(input logic [9:0] a, input logic wr, input logic [15:0] v,
                       input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= wr;
        dat <= {16'h0, v};
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 16'($urandom), 4'hf);
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            cmp(rdat, {16'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'hb328));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(10'h08c, 16'h3000);
        rd(10'h090, 16'h3000);
        rd(10'h094, 16'h630c);
        rd(10'h0c0, 16'h0320);
        rd(10'h050, 16'h0001);
        // random, all-ones and all-zero fields; reserved bits keep defaults
        for (int i = 0; i < 15; i++) begin
            d = (i < 5) ? 16'($urandom) : (i < 10) ? 16'hffff : 16'h0;
            d = (d & mk[i % 5]) | ((i % 5 < 2) ? 16'h1000 : 16'h0);
            bus(ad[i % 5], 1'b1, d, 4'h3);
            rd(ad[i % 5], d);
            case (i % 5)
                0: cmp_pin({ra, ca, fa}, {d[6:4], d[3:0], d[13]});
                1: cmp_pin({rb, cb, fb}, {d[6:4], d[3:0], d[13]});
                2: cmp_pin({tc, tbb, ta}, {d[15:11], d[10:6], d[4:0]});
                3: cmp_pin({w, dl}, d[12:0]);
                default: cmp_pin(ds, d[1:0]);
            endcase
        end
        bus(10'h050, 1'b1, 16'h2, 4'h1);
        cmp_pin(ds, 2'h2);
        bus(10'h094, 1'b1, 16'hffdf, 4'h1);
        rd(10'h094, 16'h00df);
        bus(10'h3fc, 1'b1, 16'hffff, 4'h3);
        rd(10'h3fc, 16'h0);
        // a request presented while ce is low must wait; it lands once ce returns
        ce <= 1'b0;
        fork
            bus(10'h0c0, 1'b1, 16'h0a55, 4'h3);
            begin
                repeat (4) @(posedge clk);
                cmp_pin({w, dl}, 13'h0000);
                ce <= 1'b1;
            end
        join
        cmp_pin({w, dl}, 13'h0a55);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(10'h094, 16'h630c);
        cmp_pin({fa, fb, ds}, {1'b1, 1'b1, 2'h1});
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0) bad_count++;
        summarize();
    end
endmodule
